// ==== rtl/pmw_power_ctrl.sv ====
// power mode, clock select and wake-up controller with AXI4-Lite registers
`timescale 1ns/100ps

module pmw_power_ctrl #(
    parameter int PORT_W = 8,
    parameter int IRQ_N = 4,
    parameter int RESET_DELAY_CYCLES = pmw_pkg::RESET_DELAY_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    // axi4-lite slave
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // wake sources
    input wire logic extReset_b,
    input wire logic [PORT_W-1:0] portAPins,
    input wire logic [IRQ_N-1:0] irqRequest,
    input wire logic [IRQ_N-1:0] irqEnable,
    input wire logic stackFull,
    input wire logic wdtOverflow,
    // oscillator and clock control
    output logic highSpeedOscEnable,
    output logic lowSpeedCrystalEnable,
    output logic lowSpeedInternalEnable,
    output logic crystalLowPower,
    output logic sysClockSelectLow,
    output logic sysClockGate,
    // core and watchdog control
    output logic coreHalt,
    output logic portHold,
    output logic wdtClear,
    output logic wdtRun,
    output logic systemReset,
    output logic pcSpReset,
    output logic resumeNext,
    output logic irqVector
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        pmw_pkg::pmw_state_t state;
        logic [1:0] cause;
        logic [31:0] delayCnt;
        logic [IRQ_N-1:0] irqAtSleep;
        logic powerDownFlag;
        logic timeoutFlag;
        logic clkSel;
        logic xtalLp;
        logic [5:0] cfgBits;
        logic [PORT_W-1:0] wakeEn;
        logic selLow;
        logic gate;
        logic [1:0] gapCnt;
        logic hsEn;
        logic lsEn;
        logic lircEn;
        logic halt;
        logic hold;
        logic wdtClr;
        logic wdtOn;
        logic sysRst;
        logic pcSp;
        logic resume;
        logic vector;
        logic extS1;
        logic extS2;
        logic [PORT_W-1:0] paS1;
        logic [PORT_W-1:0] paS2;
        logic [PORT_W-1:0] paPrev;
        logic awHave;
        logic [4:0] awAddr;
        logic wHave;
        logic [7:0] wData;
        logic wLane0;
        logic awReady;
        logic wReady;
        logic bValid;
        logic [1:0] bResp;
        logic arReady;
        logic rValid;
        logic [7:0] rData;
        logic [1:0] rResp;
    } pmw_regs_t;

    pmw_regs_t r;
    pmw_regs_t next_r;

    localparam pmw_regs_t REGS_RESET = '{
        state: pmw_pkg::ST_RUN,
        clkSel: pmw_pkg::CTRL_RESET[pmw_pkg::CTRL_CLK_SEL],
        xtalLp: pmw_pkg::CTRL_RESET[pmw_pkg::CTRL_XTAL_LP],
        cfgBits: pmw_pkg::CONFIG_RESET,
        hsEn: 1'b1,
        lircEn: 1'b1,
        wdtOn: 1'b1,
        extS1: 1'b1,
        extS2: 1'b1,
        paS1: '1,
        paS2: '1,
        paPrev: '1,
        awReady: 1'b1,
        wReady: 1'b1,
        arReady: 1'b1,
        default: '0
    };

    localparam logic [31:0] RST_DELAY = RESET_DELAY_CYCLES[31:0];

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        logic [1:0] osc;
        logic [1:0] wdtSrc;
        logic lxtCfg;
        logic wantLow;
        logic doWrite;
        logic sleepCmd;
        logic clrCmd;
        logic [PORT_W-1:0] portFall;
        logic portWake;
        logic irqWake;
        logic [31:0] sst;
        next_r = r;
        osc = r.cfgBits[pmw_pkg::CFG_OSC_LO +: 2];
        wdtSrc = r.cfgBits[pmw_pkg::CFG_WDT_LO +: 2];
        lxtCfg = (osc == pmw_pkg::OSC_HIGH_SPEED_INTERNAL_OSC_LXT);
        doWrite = 1'b0;
        sleepCmd = 1'b0;
        clrCmd = 1'b0;

        // synchronisers; edges judged only on the second stage
        next_r.extS1 = extReset_b;
        next_r.extS2 = r.extS1;
        next_r.paS1 = portAPins;
        next_r.paS2 = r.paS1;
        next_r.paPrev = r.paS2;
        portFall = r.paPrev & ~r.paS2 & r.wakeEn;
        portWake = |portFall;
        // only requests that were clear at sleep entry may wake
        irqWake = |(irqRequest & ~r.irqAtSleep);

        // single-cycle pulses
        next_r.wdtClr = 1'b0;
        next_r.pcSp = 1'b0;
        next_r.resume = 1'b0;
        next_r.vector = 1'b0;

        // ---------------- axi write channel ----------------
        if (s_axi_awvalid && r.awReady) begin
            next_r.awHave = 1'b1;
            next_r.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && r.wReady) begin
            next_r.wHave = 1'b1;
            next_r.wData = s_axi_wdata[7:0];
            next_r.wLane0 = s_axi_wstrb[0];
        end
        if (r.bValid && s_axi_bready) begin
            next_r.bValid = 1'b0;
        end
        if (r.awHave && r.wHave && !r.bValid) begin
            doWrite = r.wLane0;
            next_r.awHave = 1'b0;
            next_r.wHave = 1'b0;
            next_r.bValid = 1'b1;
            next_r.bResp = pmw_pkg::RESP_OKAY;
            case (r.awAddr)
                pmw_pkg::ADDR_CTRL: begin
                    if (doWrite) begin
                        next_r.clkSel = r.wData[pmw_pkg::CTRL_CLK_SEL];
                        next_r.xtalLp = r.wData[pmw_pkg::CTRL_XTAL_LP];
                    end
                end
                pmw_pkg::ADDR_CONFIG: begin
                    if (doWrite) begin
                        next_r.cfgBits = r.wData[5:0];
                    end
                end
                pmw_pkg::ADDR_WAKE_EN: begin
                    if (doWrite) begin
                        next_r.wakeEn = r.wData[PORT_W-1:0];
                    end
                end
                pmw_pkg::ADDR_COMMAND: begin
                    sleepCmd = doWrite && r.wData[pmw_pkg::CMD_SLEEP];
                    clrCmd = doWrite && r.wData[pmw_pkg::CMD_CLR_WDT];
                end
                pmw_pkg::ADDR_STATUS: begin
                end
                default: begin
                    next_r.bResp = pmw_pkg::RESP_SLVERR;
                end
            endcase
        end

        // ---------------- axi read channel ----------------
        if (r.rValid && s_axi_rready) begin
            next_r.rValid = 1'b0;
        end
        if (s_axi_arvalid && r.arReady) begin
            next_r.rValid = 1'b1;
            next_r.rResp = pmw_pkg::RESP_OKAY;
            case (s_axi_araddr)
                pmw_pkg::ADDR_CTRL: begin
                    next_r.rData = {6'h00, r.xtalLp, r.clkSel};
                end
                pmw_pkg::ADDR_CONFIG: begin
                    next_r.rData = {2'h0, r.cfgBits};
                end
                pmw_pkg::ADDR_WAKE_EN: begin
                    next_r.rData = 8'(r.wakeEn);
                end
                pmw_pkg::ADDR_COMMAND: begin
                    next_r.rData = 8'h00;
                end
                pmw_pkg::ADDR_STATUS: begin
                    next_r.rData = {r.cause, r.selLow, r.state,
                                    r.timeoutFlag, r.powerDownFlag};
                end
                default: begin
                    next_r.rData = 8'h00;
                    next_r.rResp = pmw_pkg::RESP_SLVERR;
                end
            endcase
        end

        // clear-watchdog instruction
        if (clrCmd) begin
            next_r.powerDownFlag = 1'b0;
            next_r.wdtClr = 1'b1;
        end

        // ---------------- mode sequencer ----------------
        case (r.state)
            pmw_pkg::ST_RUN: begin
                next_r.sysRst = 1'b0;
                if (sleepCmd) begin
                    next_r.state = pmw_pkg::ST_SLEEP;
                    next_r.halt = 1'b1;
                    next_r.hold = 1'b1;
                    next_r.powerDownFlag = 1'b1;
                    next_r.timeoutFlag = 1'b0;
                    next_r.wdtClr = 1'b1;
                    next_r.irqAtSleep = irqRequest;
                end else if (wdtOverflow) begin
                    next_r.timeoutFlag = 1'b1;
                    next_r.sysRst = 1'b1;
                end
            end
            pmw_pkg::ST_SLEEP: begin
                // priority: reset, watchdog, port, interrupt
                if (!r.extS2) begin
                    next_r.cause = pmw_pkg::WAKE_EXT;
                    next_r.state = pmw_pkg::ST_RST_DELAY;
                    next_r.delayCnt = RST_DELAY;
                    next_r.sysRst = 1'b1;
                end else if (wdtOverflow) begin
                    next_r.cause = pmw_pkg::WAKE_WDT;
                    next_r.state = pmw_pkg::ST_START_DELAY;
                    next_r.timeoutFlag = 1'b1;
                end else if (portWake) begin
                    next_r.cause = pmw_pkg::WAKE_PORT;
                    next_r.state = pmw_pkg::ST_START_DELAY;
                end else if (irqWake) begin
                    next_r.cause = pmw_pkg::WAKE_IRQ;
                    next_r.state = pmw_pkg::ST_START_DELAY;
                end
            end
            pmw_pkg::ST_RST_DELAY: begin
                if (r.delayCnt <= 32'h00000001) begin
                    next_r.state = pmw_pkg::ST_START_DELAY;
                end else begin
                    next_r.delayCnt = r.delayCnt - 32'h00000001;
                end
            end
            pmw_pkg::ST_START_DELAY: begin
                if (r.delayCnt <= 32'h00000001) begin
                    next_r.state = pmw_pkg::ST_RUN;
                    next_r.halt = 1'b0;
                    next_r.hold = 1'b0;
                    next_r.sysRst = 1'b0;
                    case (r.cause)
                        pmw_pkg::WAKE_WDT: begin
                            next_r.pcSp = 1'b1;
                        end
                        pmw_pkg::WAKE_PORT: begin
                            next_r.resume = 1'b1;
                        end
                        pmw_pkg::WAKE_IRQ: begin
                            if (|(irqRequest & irqEnable) && !stackFull) begin
                                next_r.vector = 1'b1;
                            end else begin
                                next_r.resume = 1'b1;
                            end
                        end
                        default: begin
                        end
                    endcase
                end else begin
                    next_r.delayCnt = r.delayCnt - 32'h00000001;
                end
            end
            default: begin
                next_r.state = pmw_pkg::ST_RUN;
            end
        endcase

        // load the start-up delay on entry to the start-up state
        if (next_r.state == pmw_pkg::ST_START_DELAY &&
            r.state != pmw_pkg::ST_START_DELAY) begin
            sst = pmw_pkg::SST_LONG_CYC;
            if (osc != pmw_pkg::OSC_HS_CRYSTAL &&
                r.cfgBits[pmw_pkg::CFG_SST_SHORT]) begin
                sst = pmw_pkg::SST_SHORT_CYC;
            end
            next_r.delayCnt = sst;
        end

        // ---------------- oscillators ----------------
        wantLow = lxtCfg && r.clkSel;
        next_r.lsEn = lxtCfg;
        next_r.lircEn = !r.cfgBits[pmw_pkg::CFG_LOW_SPEED_INTERNAL_OSC_OFF];
        next_r.xtalLp = next_r.xtalLp && lxtCfg;
        if (r.state == pmw_pkg::ST_SLEEP) begin
            next_r.hsEn = 1'b0;
        end else begin
            next_r.hsEn = !(r.selLow && wantLow);
        end
        next_r.wdtOn = !(r.state == pmw_pkg::ST_SLEEP &&
                         wdtSrc == pmw_pkg::WDT_SRC_SYS);

        // break-before-make clock switch
        if (wantLow != r.selLow || r.state == pmw_pkg::ST_SLEEP) begin
            next_r.gate = 1'b0;
            next_r.gapCnt = 2'h0;
            if (!r.gate && r.state != pmw_pkg::ST_SLEEP) begin
                next_r.selLow = wantLow;
            end
        end else if (!r.gate) begin
            if (r.gapCnt == pmw_pkg::SWITCH_GAP_CYC) begin
                next_r.gate = 1'b1;
            end else begin
                next_r.gapCnt = r.gapCnt + 2'h1;
            end
        end
        if (!wantLow && !r.selLow && !r.hsEn) begin
            next_r.gate = 1'b0; // wait for fast oscillator first
        end

        // ready flags for the next cycle
        next_r.awReady = !next_r.awHave;
        next_r.wReady = !next_r.wHave;
        next_r.arReady = !next_r.rValid;
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            r <= REGS_RESET;
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign s_axi_awready = r.awReady;
    assign s_axi_wready = r.wReady;
    assign s_axi_bvalid = r.bValid;
    assign s_axi_bresp = r.bResp;
    assign s_axi_arready = r.arReady;
    assign s_axi_rvalid = r.rValid;
    assign s_axi_rdata = {24'h000000, r.rData};
    assign s_axi_rresp = r.rResp;
    assign highSpeedOscEnable = r.hsEn;
    assign lowSpeedCrystalEnable = r.lsEn;
    assign lowSpeedInternalEnable = r.lircEn;
    assign crystalLowPower = r.xtalLp;
    assign sysClockSelectLow = r.selLow;
    assign sysClockGate = r.gate;
    assign coreHalt = r.halt;
    assign portHold = r.hold;
    assign wdtClear = r.wdtClr;
    assign wdtRun = r.wdtOn;
    assign systemReset = r.sysRst;
    assign pcSpReset = r.pcSp;
    assign resumeNext = r.resume;
    assign irqVector = r.vector;

endmodule

// ==== rtl/pmw_pkg.sv ====
// constants and types for the power mode and wake-up controller
package pmw_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [4:0] ADDR_CTRL = 5'h00;
    localparam logic [4:0] ADDR_CONFIG = 5'h04;
    localparam logic [4:0] ADDR_WAKE_EN = 5'h08;
    localparam logic [4:0] ADDR_COMMAND = 5'h0C;
    localparam logic [4:0] ADDR_STATUS = 5'h10;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CTRL_CLK_SEL = 0;
    localparam int CTRL_XTAL_LP = 1;
    localparam int CFG_OSC_LO = 0;
    localparam int CFG_WDT_LO = 2;
    localparam int CFG_LOW_SPEED_INTERNAL_OSC_OFF = 4;
    localparam int CFG_SST_SHORT = 5;
    localparam int CMD_SLEEP = 0;
    localparam int CMD_CLR_WDT = 1;

    // ----------------------------------------------------------------
    // reset values and response codes
    // ----------------------------------------------------------------
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [5:0] CONFIG_RESET = 6'h03;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] OSC_HS_CRYSTAL = 2'h0;
    localparam logic [1:0] OSC_EXT_RC = 2'h1;
    localparam logic [1:0] OSC_HS_INT_RC = 2'h2;
    localparam logic [1:0] OSC_HIGH_SPEED_INTERNAL_OSC_LXT = 2'h3;
    localparam logic [1:0] WDT_SRC_LOW_SPEED_INTERNAL_OSC = 2'h0;
    localparam logic [1:0] WDT_SRC_LXT = 2'h1;
    localparam logic [1:0] WDT_SRC_SYS = 2'h2;
    localparam logic [1:0] WAKE_EXT = 2'h0;
    localparam logic [1:0] WAKE_PORT = 2'h1;
    localparam logic [1:0] WAKE_IRQ = 2'h2;
    localparam logic [1:0] WAKE_WDT = 2'h3;

    typedef enum logic [2:0] {
        ST_RUN = 3'h0,
        ST_SLEEP = 3'h1,
        ST_RST_DELAY = 3'h2,
        ST_START_DELAY = 3'h3
    } pmw_state_t;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 10;
    localparam int RESET_DELAY_US = 100000;
    localparam int RESET_DELAY_CYC = RESET_DELAY_US * CLK_MHZ;
    localparam logic [31:0] SST_SHORT_CYC = 32'h00000002;
    localparam logic [31:0] SST_LONG_CYC = 32'h00000080;
    localparam logic [1:0] SWITCH_GAP_CYC = 2'h2;

endpackage

// ==== tb/pmw_ctrl_monitor.sv ====
// concurrent checks on the power controller ports
`timescale 1ns/100ps
module pmw_ctrl_monitor (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic highSpeedOscEnable,
    input wire logic lowSpeedCrystalEnable,
    input wire logic crystalLowPower,
    input wire logic sysClockSelectLow,
    input wire logic sysClockGate,
    input wire logic coreHalt,
    input wire logic portHold,
    input wire logic wdtClear,
    input wire logic systemReset,
    input wire logic pcSpReset
);
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    // ------------------------------------------------------------
    // sequences
    // ------------------------------------------------------------
    sequence gate_shut2;
        !sysClockGate ##1 !sysClockGate;
    endsequence
    sequence sleep_entry;
        $rose(coreHalt) && !systemReset;
    endsequence
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_write_resp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp lost");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read not answered");
    a_halt_port_pair: assert property (
        coreHalt == portHold) else $error("halt and port hold differ");
    a_entry_clears_wdt: assert property (
        sleep_entry |-> wdtClear) else $error("no watchdog clear on sleep");
    a_sleep_fast_off: assert property (
        sleep_entry |-> ##[0:2] !highSpeedOscEnable)
        else $error("fast oscillator runs in sleep");
    a_lp_needs_xtal: assert property (
        crystalLowPower |-> lowSpeedCrystalEnable)
        else $error("low power bit without crystal");
    a_slow_needs_xtal: assert property (
        sysClockSelectLow |-> lowSpeedCrystalEnable)
        else $error("slow clock without crystal");
    a_slow_fast_off: assert property (
        sysClockSelectLow && sysClockGate |-> !highSpeedOscEnable)
        else $error("fast oscillator runs in slow mode");
    a_switch_no_glitch: assert property (
        $changed(sysClockSelectLow) |-> gate_shut2)
        else $error("clock select moved with gate open");
    a_wake_pulse_once: assert property (
        pcSpReset |=> !pcSpReset) else $error("pc reset pulse too long");
endmodule

bind pmw_power_ctrl pmw_ctrl_monitor mon_u (.clk_sys, .rst_b, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .highSpeedOscEnable, .lowSpeedCrystalEnable,
    .crystalLowPower, .sysClockSelectLow, .sysClockGate, .coreHalt,
    .portHold, .wdtClear, .systemReset, .pcSpReset);

// ==== tb/tb_top.sv ====
// self-checking bench for the power mode and wake-up controller
`timescale 1ns/100ps
module tb_top;
    logic clk_sys = 0, rst_b = 0, extReset_b = 1, stackFull = 0;
    logic wdtOverflow = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, d, rnd = 32'h5D4C;
    logic [3:0] s_axi_wstrb = 4'hF, irqRequest = 0, irqEnable = 0, got;
    logic [7:0] portAPins = 8'hFF, pinOn, pinOff;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [2:0] k;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, highSpeedOscEnable, lowSpeedCrystalEnable;
    logic crystalLowPower, sysClockSelectLow, sysClockGate, coreHalt;
    logic portHold, wdtRun, systemReset, pcSpReset, resumeNext, irqVector;
    logic lowSpeedInternalEnable, wdtClear;
    int fails = 0, samples_checked = 0, n;

    pmw_power_ctrl #(.RESET_DELAY_CYCLES(20)) dut_u (.clk_sys, .rst_b,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .extReset_b, .portAPins, .irqRequest, .irqEnable,
        .stackFull, .wdtOverflow, .highSpeedOscEnable, .lowSpeedCrystalEnable,
        .lowSpeedInternalEnable, .crystalLowPower, .sysClockSelectLow,
        .sysClockGate, .coreHalt, .portHold, .wdtClear, .wdtRun,
        .systemReset, .pcSpReset, .resumeNext, .irqVector);

    initial begin
        forever #50 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string w, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", w, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] v,
                      input logic [1:0] er);
        int c;
        logic ta, tw, tb;
        logic [1:0] tr;
        c = 0;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge clk_sys);
            ta = s_axi_awready;
            tw = s_axi_wready;
            tb = s_axi_bvalid;
            tr = s_axi_bresp;
            @(posedge clk_sys);
            c++;
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end while (!tb && c < 50);
        s_axi_bready <= 1'b0;
        chk("bvalid", tb, 1);
        chk("bresp", tr, er);
    endtask

    task automatic rd(input logic [4:0] a);
        int c;
        logic ta, tr;
        c = 0;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge clk_sys);
            ta = s_axi_arready;
            tr = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk_sys);
            c++;
            if (ta) s_axi_arvalid <= 1'b0;
        end while (!tr && c < 50);
        s_axi_rready <= 1'b0;
        chk("rvalid", tr, 1);
    endtask

    task automatic rdc(input string w, input logic [4:0] a,
                       input logic [31:0] m, e);
        rd(a);
        chk(w, d & m, e);
    endtask

    task automatic waitc(input logic s);
        int c;
        c = 0;
        while (!(sysClockGate && sysClockSelectLow === s) && c < 40) begin
            @(negedge clk_sys);
            c++;
        end
        chk("clock switch", {sysClockGate, sysClockSelectLow}, {1'b1, s});
    endtask

    // sleep, then wake by source 0 ext, 1 port, 2 irq, 3 watchdog
    task automatic slp(input int src, input logic wrun);
        wr(pmw_pkg::ADDR_COMMAND, 8'h01, pmw_pkg::RESP_OKAY);
        @(negedge clk_sys);
        chk("halt and hold", {portHold, coreHalt}, 2'b11);
        chk("wdt run", wdtRun, wrun);
        rdc("status", pmw_pkg::ADDR_STATUS, 3, 1);
        if (src == 1) portAPins <= ~pinOff;
        if (src == 1 || src == 2) begin
            repeat (10) @(posedge clk_sys);
            chk("still asleep", coreHalt, 1);
        end
        @(posedge clk_sys);
        case (src)
            0: extReset_b <= 1'b0;
            1: portAPins <= ~(pinOff | pinOn);
            2: irqRequest[0] <= 1'b1;
            default: wdtOverflow <= 1'b1;
        endcase
        @(posedge clk_sys);
        wdtOverflow <= 1'b0;
        if (src == 0) repeat (3) @(posedge clk_sys);
        extReset_b <= 1'b1;
        got = 0;
        n = 0;
        while (coreHalt && n < 600) begin
            @(negedge clk_sys);
            n++;
            got |= {systemReset, pcSpReset, resumeNext, irqVector};
        end
        @(negedge clk_sys);
        got |= {systemReset, pcSpReset, resumeNext, irqVector};
    endtask

    initial begin
        repeat (30000) @(posedge clk_sys);
        fails++;
        give_verdict();
    end

    initial begin
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'b1;
        rdc("ctrl", pmw_pkg::ADDR_CTRL, 32'hFFFFFFFF, 0);
        rdc("config", pmw_pkg::ADDR_CONFIG, 32'hFFFFFFFF, 3);
        rdc("status", pmw_pkg::ADDR_STATUS, 32'h3F, 0);
        rd(5'h14);
        chk("bad read", r, pmw_pkg::RESP_SLVERR);
        wr(5'h14, 8'hFF, pmw_pkg::RESP_SLVERR);
        $display("test registers finished");
        wr(pmw_pkg::ADDR_CTRL, 8'h02, pmw_pkg::RESP_OKAY);
        chk("crystal lp", crystalLowPower, 1);
        wr(pmw_pkg::ADDR_CTRL, 8'h03, pmw_pkg::RESP_OKAY);
        waitc(1'b1);
        chk("fast osc", highSpeedOscEnable, 0);
        chk("crystal run", lowSpeedCrystalEnable, 1);
        wr(pmw_pkg::ADDR_CTRL, 8'h02, pmw_pkg::RESP_OKAY);
        waitc(1'b0);
        wr(pmw_pkg::ADDR_CONFIG, 8'h01, pmw_pkg::RESP_OKAY);
        wr(pmw_pkg::ADDR_CTRL, 8'h03, pmw_pkg::RESP_OKAY);
        repeat (8) @(posedge clk_sys);
        chk("select ignored", sysClockSelectLow, 0);
        chk("crystal off", {lowSpeedCrystalEnable, crystalLowPower},
            0);
        wr(pmw_pkg::ADDR_CTRL, 8'h00, pmw_pkg::RESP_OKAY);
        $display("test clock modes finished");
        for (int i = 0; i < 2; i++) begin
            wr(pmw_pkg::ADDR_CONFIG, i ? 8'h32 : 8'h03, pmw_pkg::RESP_OKAY);
            slp(3, 1'b1);
            chk("low rc", lowSpeedInternalEnable, i == 0);
            chk("wdt wake", got, 4'b0100);
            chk("delay", n >= (i ? 2 : 128) && n <= (i ? 6 : 132),
                1);
            rdc("status", pmw_pkg::ADDR_STATUS, 3, 3);
        end
        wr(pmw_pkg::ADDR_COMMAND, 8'h02, pmw_pkg::RESP_OKAY);
        rdc("status", pmw_pkg::ADDR_STATUS, 1, 0);
        $display("test watchdog wake finished");
        wr(pmw_pkg::ADDR_CONFIG, 8'h0B, pmw_pkg::RESP_OKAY);
        for (int i = 0; i < 2; i++) begin
            rnd = lfsr(rnd);
            k = rnd[2:0];
            pinOn = 8'h01 << k;
            pinOff = 8'h01 << (k + 3'h1);
            wr(pmw_pkg::ADDR_WAKE_EN, pinOn, pmw_pkg::RESP_OKAY);
            slp(1, 1'b0);
            chk("port wake", got, 4'b0010);
            portAPins <= 8'hFF;
            repeat (4) @(posedge clk_sys);
        end
        wr(pmw_pkg::ADDR_CONFIG, 8'h03, pmw_pkg::RESP_OKAY);
        for (int m = 0; m < 3; m++) begin
            irqEnable <= (m == 1) ? 4'h0 : 4'hF;
            stackFull <= (m == 2);
            irqRequest <= 4'h2;
            slp(2, 1'b1);
            chk("irq wake", got,
                (m == 0) ? 4'b0001 : 4'b0010);
        end
        irqRequest <= 4'h0;
        $display("test port and irq wake finished");
        slp(0, 1'b1);
        chk("ext wake", got[3], 1);
        chk("ext delay", n >= 145 && n <= 160, 1);
        $display("test external wake finished");
        give_verdict();
    end
endmodule
